// ### logic/swk_mode_pkg.sv
package swk_mode_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_POWER_CMD  = 8'h00;
    localparam logic [7:0] ADDR_CAN_MODE   = 8'h04;
    localparam logic [7:0] ADDR_SWK_CFG    = 8'h08;
    localparam logic [7:0] ADDR_STATUS     = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_VALID_BIT   = 0;
    localparam int ERROR_FLAG_BIT  = 1;
    localparam int STAT_EFF_LSB    = 0;
    localparam int STAT_ARMED_BIT  = 3;
    localparam int STAT_SILENT_BIT = 4;
    localparam int STAT_WOKEN_BIT  = 5;
    localparam int STAT_POWER_LSB  = 8;
    localparam int IRQ_WAKE_BIT    = 0;
    localparam int IRQ_SILENT_BIT  = 1;
    localparam int IRQ_ERROR_BIT   = 2;
    localparam int IRQ_WIDTH       = 3;

    // ------------------------------------------------------------------
    // Programmed transceiver mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CAN_OFF        = 3'h0;
    localparam logic [2:0] CAN_WAKE       = 3'h1;
    localparam logic [2:0] CAN_RX         = 3'h2;
    localparam logic [2:0] CAN_NORMAL     = 3'h3;
    localparam logic [2:0] CAN_OFF_HI     = 3'h4;
    localparam logic [2:0] CAN_SWK        = 3'h5;
    localparam logic [2:0] CAN_RX_SWK     = 3'h6;
    localparam logic [2:0] CAN_NORMAL_SWK = 3'h7;

    // ------------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [2:0]           CAN_MODE_RESET   = 3'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic [1:0]           RESP_OKAY        = 2'h0;
    localparam logic [1:0]           RESP_SLVERR      = 2'h2;

    // Chip power modes
    typedef enum logic [1:0] {
        POWER_NORMAL  = 2'b00,
        POWER_STOP    = 2'b01,
        POWER_SLEEP   = 2'b10,
        POWER_RESTART = 2'b11
    } power_type;

    // Effective transceiver modes
    typedef enum logic [2:0] {
        EFF_OFF        = 3'b000,
        EFF_WAKE       = 3'b001,
        EFF_RX         = 3'b010,
        EFF_NORMAL     = 3'b011,
        EFF_WOKEN      = 3'b100,
        EFF_SWK        = 3'b101,
        EFF_RX_SWK     = 3'b110,
        EFF_NORMAL_SWK = 3'b111
    } eff_type;

endpackage

// ### logic/axil_reg_slave.sv
`timescale 1ns/1ps
module axil_reg_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    import swk_mode_pkg::*;

    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        r_valid;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
    } slave_type;

    slave_type state;
    slave_type next_state;

    // Handshake outputs
    assign awready = !state.aw_full && !state.b_valid;
    assign wready  = !state.w_full && !state.b_valid;
    assign arready = !state.r_valid;
    assign bvalid  = state.b_valid;
    assign bresp   = state.b_resp;
    assign rvalid  = state.r_valid;
    assign rdata   = state.r_data;
    assign rresp   = state.r_resp;

    // Register file strobes
    assign wr_en   = state.aw_full && state.w_full && !state.b_valid;
    assign wr_addr = state.aw_addr;
    assign wr_data = state.w_data;
    assign wr_strb = state.w_strb;
    assign rd_en   = arvalid && !state.r_valid;
    assign rd_addr = araddr;

    // Channel capture and answers
    always_comb begin
        next_state = state;
        if (awvalid && awready) begin
            next_state.aw_full = 1'b1;
            next_state.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_state.w_full = 1'b1;
            next_state.w_data = wdata;
            next_state.w_strb = wstrb;
        end
        if (wr_en) begin
            next_state.aw_full = 1'b0;
            next_state.w_full  = 1'b0;
            next_state.b_valid = 1'b1;
            next_state.b_resp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (state.b_valid && bready) begin
            next_state.b_valid = 1'b0;
        end
        if (rd_en) begin
            next_state.r_valid = 1'b1;
            next_state.r_data  = rd_data;
            next_state.r_resp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (state.r_valid && rready) begin
            next_state.r_valid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule

// ### logic/trx_mode_map.sv
`timescale 1ns/1ps
module trx_mode_map (
    input  wire swk_mode_pkg::power_type power,
    input  wire logic [2:0]              can_mode,
    input  wire logic                    error_flag,
    input  wire logic                    woken,
    output swk_mode_pkg::eff_type        eff_mode,
    output logic                         swk_active
);
    import swk_mode_pkg::*;

    eff_type base;

    // Programmed code to effective mode
    always_comb begin
        case (can_mode)
            CAN_OFF:        base = EFF_OFF; // R1
            CAN_WAKE:       base = EFF_WAKE;
            CAN_RX:         base = EFF_RX;
            CAN_NORMAL:     base = (power == POWER_NORMAL) ? EFF_NORMAL : EFF_WAKE; // R9
            CAN_OFF_HI:     base = EFF_OFF;
            CAN_SWK:        base = error_flag ? EFF_WAKE : EFF_SWK; // R10 R11
            CAN_RX_SWK:     base = error_flag ? EFF_RX : EFF_RX_SWK; // R10 R11
            CAN_NORMAL_SWK: base = error_flag ? EFF_NORMAL : EFF_NORMAL_SWK; // R10 R11
            default:        base = EFF_OFF;
        endcase
        if (woken && (base == EFF_WAKE || base == EFF_SWK)) begin
            eff_mode = EFF_WOKEN; // R16
        end else begin
            eff_mode = base;
        end
    end

    // Frame monitor runs in the three selective modes
    assign swk_active = (eff_mode == EFF_SWK) || (eff_mode == EFF_RX_SWK) || (eff_mode == EFF_NORMAL_SWK);

endmodule

// ### logic/can_swk_mode_ctrl.sv
`timescale 1ns/1ps
// What this block does
// R1: Mode codes 000/100 off, 001 wake, 010 rx, 011 normal, 101/110/111 selective.
// R2: Mode field writes take effect only in Normal power mode.
// R3: Normal-selective passes rx and tx, monitors bus and flags bus silence.
// R4: Wake frame in normal-selective raises wake interrupt without pulling rx low.
// R5: Receive-only selective passes bus data to rx and never transmits.
// R6: Error flag is zero only with selective wake enabled and no overflow; code also holds it zero from reset until a selective code is entered.
// R7: Mode field reads programmed value; effective mode shown separately.
// R8: Leaving Normal may rewrite the two low mode bits; top bit kept.
// R9: Stop keeps the bits; 011 acts wake-capable, others keep meaning.
// R10: Stop with 101/110/111 keeps selective only with error flag clear.
// R11: Error flag set blocks frame detection, top mode bit stays.
// R12: Controller programs selective code in Normal before a low-power command.
// R13: Sleep maps 001-011 to 001, keeps off, maps selective codes to 101.
// R14: Wake frame in Sleep goes Restart, clears config-valid, flag clear, 101.
// R15: Controller re-enters selective Sleep through the documented sequence.
// R16: After a wake the transceiver stays woken until a mode change rearms it.
// R17: Commanding Sleep from Normal with a woken transceiver rearms it automatically.
// R18: Armed flag shows correct selective arming; cleared by wake, top bit clear, or config-valid clear with a selective code.
module can_swk_mode_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        wake_up_frame,
    input  wire logic        wake_up_pattern,
    input  wire logic        counter_overflow,
    input  wire logic        bus_quiet,
    input  wire logic        bus_rx,
    input  wire logic        txd_pin,
    output logic             rxd_pin,
    output logic             bus_tx,
    output swk_mode_pkg::eff_type    trx_mode,
    output swk_mode_pkg::power_type  power_mode,
    output logic             irq
);
    import swk_mode_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        power_type            power;
        logic [2:0]           can_mode;
        logic                 wake_config_valid_bit;
        logic                 swk_error_flag;
        logic                 swk_armed_flag;
        logic                 bus_silence_flag;
        logic                 woken;
        logic [IRQ_WIDTH-1:0] irq_status;
        logic [IRQ_WIDTH-1:0] irq_enable;
        logic                 rxd;
        logic                 txd;
    } ctrl_type;

    ctrl_type state;
    ctrl_type next_state;

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;
    eff_type     eff_mode;
    logic        swk_active;

    // ------------------------------------------------------------------
    // Bus slave and mode mapping
    // ------------------------------------------------------------------
    axil_reg_slave bus_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    trx_mode_map mode_map (
        .power      (state.power),
        .can_mode   (state.can_mode),
        .error_flag (state.swk_error_flag),
        .woken      (state.woken),
        .eff_mode   (eff_mode),
        .swk_active (swk_active)
    );

    // ------------------------------------------------------------------
    // Decode and events
    // ------------------------------------------------------------------
    logic       wr_lane;
    logic       wr_power;
    logic       wr_mode;
    logic       wr_cfg;
    logic       wr_clear;
    logic       wr_enable;
    logic       swk_code_now;
    logic       swk_code_new;
    logic [2:0] new_mode;
    logic       wuf_hit;
    logic       wup_hit;
    logic       ovf_hit;
    logic       wake;

    // Byte lane 0 carries every field
    assign wr_lane   = wr_en && wr_strb[0];
    assign wr_power  = wr_lane && (wr_addr == ADDR_POWER_CMD);
    assign wr_mode   = wr_lane && (wr_addr == ADDR_CAN_MODE) && (state.power == POWER_NORMAL); // R2
    assign wr_cfg    = wr_lane && (wr_addr == ADDR_SWK_CFG);
    assign wr_clear  = wr_lane && (wr_addr == ADDR_IRQ_CLEAR);
    assign wr_enable = wr_lane && (wr_addr == ADDR_IRQ_ENABLE);
    assign new_mode  = wr_data[2:0];

    // Selective codes are 101, 110 and 111
    assign swk_code_now = state.can_mode[2] && (state.can_mode[1:0] != 2'b00);
    assign swk_code_new = new_mode[2] && (new_mode[1:0] != 2'b00);

    // Wake sources; a set error flag stops the frame monitor
    assign wuf_hit = wake_up_frame && swk_active; // R11
    assign wup_hit = wake_up_pattern && (eff_mode == EFF_WAKE);
    assign ovf_hit = counter_overflow && swk_active;
    assign wake    = wuf_hit || wup_hit || ovf_hit;

    assign wr_ok = (wr_addr == ADDR_POWER_CMD) || (wr_addr == ADDR_CAN_MODE) || (wr_addr == ADDR_SWK_CFG)
                   || (wr_addr == ADDR_IRQ_CLEAR) || (wr_addr == ADDR_IRQ_ENABLE);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr)
            ADDR_POWER_CMD:  rd_data[1:0] = state.power;
            ADDR_CAN_MODE:   rd_data[2:0] = state.can_mode; // R7
            ADDR_SWK_CFG: begin
                rd_data[CFG_VALID_BIT]  = state.wake_config_valid_bit;
                rd_data[ERROR_FLAG_BIT] = state.swk_error_flag;
            end
            ADDR_STATUS: begin
                rd_data[STAT_EFF_LSB +: 3]   = eff_mode; // R7
                rd_data[STAT_ARMED_BIT]      = state.swk_armed_flag;
                rd_data[STAT_SILENT_BIT]     = state.bus_silence_flag;
                rd_data[STAT_WOKEN_BIT]      = state.woken;
                rd_data[STAT_POWER_LSB +: 2] = state.power;
            end
            ADDR_IRQ_STATUS: rd_data[IRQ_WIDTH-1:0] = state.irq_status;
            ADDR_IRQ_ENABLE: rd_data[IRQ_WIDTH-1:0] = state.irq_enable;
            ADDR_IRQ_CLEAR:  rd_data = 32'h0000_0000;
            default:         rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Power mode commands
        if (wr_power) begin
            case (wr_data[1:0])
                POWER_NORMAL: begin
                    next_state.power = POWER_NORMAL;
                end
                POWER_STOP: begin
                    if (state.power == POWER_NORMAL) begin
                        next_state.power = POWER_STOP; // R9
                    end
                end
                POWER_SLEEP: begin
                    if (state.power == POWER_NORMAL) begin
                        next_state.power = POWER_SLEEP;
                        next_state.woken = 1'b0; // R17
                        if (state.can_mode[1:0] != 2'b00) begin
                            next_state.can_mode = {state.can_mode[2], 2'b01}; // R8 R13
                        end
                    end
                end
                default: next_state.power = state.power;
            endcase
        end

        // Mode field write with configuration check
        if (wr_mode) begin
            next_state.can_mode = new_mode;
            if (new_mode != state.can_mode) begin
                next_state.woken = 1'b0; // R16
            end
            if (!new_mode[2]) begin
                next_state.swk_armed_flag = 1'b0; // R18
            end else if (swk_code_new && !swk_code_now) begin
                next_state.swk_error_flag = !state.wake_config_valid_bit; // R6
                next_state.swk_armed_flag = state.wake_config_valid_bit; // R18
            end
        end

        // Config valid and error flag
        if (wr_cfg && state.power == POWER_NORMAL) begin
            next_state.wake_config_valid_bit = wr_data[CFG_VALID_BIT];
            if (!wr_data[ERROR_FLAG_BIT] && !(swk_code_now && !wr_data[CFG_VALID_BIT])) begin
                next_state.swk_error_flag = 1'b0; // R6
            end
            if (swk_code_now && !wr_data[CFG_VALID_BIT]) begin
                next_state.swk_error_flag = 1'b1; // R6
                next_state.swk_armed_flag = 1'b0;
            end
        end

        // Interrupt mask and clears
        if (wr_enable) begin
            next_state.irq_enable = wr_data[IRQ_WIDTH-1:0];
        end
        if (wr_clear) begin
            next_state.irq_status = state.irq_status & ~wr_data[IRQ_WIDTH-1:0];
        end

        // Bus silence: a pattern clears, quiet bus sets
        if (wake_up_pattern) begin
            next_state.bus_silence_flag = 1'b0; // R3
        end
        if (bus_quiet && swk_active) begin
            next_state.bus_silence_flag = 1'b1; // R3
            next_state.irq_status[IRQ_SILENT_BIT] = 1'b1;
        end

        // Counter overflow disables selective wake
        if (ovf_hit) begin
            next_state.swk_error_flag = 1'b1; // R6 R11
            next_state.irq_status[IRQ_ERROR_BIT] = 1'b1;
        end

        // Wake handling, set wins over any clear above
        if (wake) begin
            next_state.woken          = 1'b1; // R16
            next_state.swk_armed_flag = 1'b0; // R18
            if (state.power == POWER_SLEEP) begin
                next_state.power = POWER_RESTART; // R14
                next_state.wake_config_valid_bit = 1'b0; // R14
                if (!wuf_hit && state.can_mode[2]) begin
                    next_state.swk_error_flag = 1'b1;
                end
            end else begin
                next_state.irq_status[IRQ_WAKE_BIT] = 1'b1; // R4
            end
        end

        // Transceiver pins; rx low only for a woken wake-capable transceiver
        case (eff_mode)
            EFF_RX, EFF_RX_SWK: begin
                next_state.rxd = bus_rx; // R5
                next_state.txd = 1'b1; // R5
            end
            EFF_NORMAL, EFF_NORMAL_SWK: begin
                next_state.rxd = bus_rx; // R3 R4
                next_state.txd = txd_pin; // R3
            end
            EFF_WOKEN: begin
                next_state.rxd = 1'b0;
                next_state.txd = 1'b1;
            end
            default: begin
                next_state.rxd = 1'b1;
                next_state.txd = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state            <= '0;
            state.power      <= POWER_NORMAL;
            state.can_mode   <= CAN_MODE_RESET;
            state.irq_enable <= IRQ_ENABLE_RESET;
            state.rxd        <= 1'b1;
            state.txd        <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign rxd_pin    = state.rxd;
    assign bus_tx     = state.txd;
    assign trx_mode   = eff_mode;
    assign power_mode = state.power;
    assign irq        = |(state.irq_status & state.irq_enable);

endmodule

// ### sim/can_swk_mode_ctrl_monitor.sv
`timescale 1ns/1ps
module can_swk_mode_ctrl_monitor (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    bvalid,
    input wire logic                    bready,
    input wire logic                    rvalid,
    input wire logic                    rready,
    input wire logic                    wake_up_frame,
    input wire logic                    txd_pin,
    input wire logic                    bus_tx,
    input wire swk_mode_pkg::eff_type   trx_mode,
    input wire swk_mode_pkg::power_type power_mode
);
    import swk_mode_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Frame arriving while armed asleep
    sequence s_frame_wake;
        power_mode == POWER_SLEEP && trx_mode == EFF_SWK && wake_up_frame;
    endsequence
    a_sleep_restart: assert property (s_frame_wake |=> power_mode == POWER_RESTART)
        else $error("no restart");
    a_sleep_set: assert property (power_mode == POWER_SLEEP |->
        trx_mode inside {EFF_OFF, EFF_WAKE, EFF_SWK, EFF_WOKEN}) else $error("bad sleep mode");
    a_sleep_rearm: assert property ($past(power_mode) == POWER_NORMAL && power_mode == POWER_SLEEP |->
        trx_mode != EFF_WOKEN) else $error("sleep not rearmed");
    a_rx_silent: assert property ($past(trx_mode) == EFF_RX_SWK |-> bus_tx)
        else $error("sent in receive-only");
    a_idle_recessive: assert property (!($past(trx_mode) inside {EFF_NORMAL, EFF_NORMAL_SWK}) |-> bus_tx)
        else $error("sent while idle");
    a_normal_pass: assert property ($past(trx_mode) == EFF_NORMAL_SWK |-> bus_tx == $past(txd_pin))
        else $error("transmit not passed");
    a_write_drop: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer stuck");
    a_read_drop: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer stuck");
endmodule
bind can_swk_mode_ctrl can_swk_mode_ctrl_monitor can_swk_mode_ctrl_monitor_i (.*);

// ### sim/can_bus_model.sv
`timescale 1ns/1ps
module can_bus_model (
    input  wire logic aclk,
    input  wire logic bus_tx,
    output logic      bus_rx,
    output logic      wake_up_frame,
    output logic      wake_up_pattern,
    output logic      counter_overflow,
    output logic      bus_quiet
);
    // Bus reads back what the transceiver sends
    assign bus_rx = bus_tx;
    initial {wake_up_frame, wake_up_pattern, counter_overflow, bus_quiet} = 4'h0;
    // One-cycle decoder event: frame, pattern, overflow, silence
    task automatic event_pulse(input logic [3:0] ev);
        @(posedge aclk);
        {wake_up_frame, wake_up_pattern, counter_overflow, bus_quiet} <= ev;
        @(posedge aclk);
        {wake_up_frame, wake_up_pattern, counter_overflow, bus_quiet} <= 4'h0;
    endtask
endmodule

// ### sim/test_can_swk_mode_ctrl.sv
`timescale 1ns/1ps
module test_can_swk_mode_ctrl;
    import swk_mode_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, txd_pin = 1'b0, bready = 1'b0, rready = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rxd_pin, bus_tx, irq, bus_rx;
    logic        wake_up_frame, wake_up_pattern, counter_overflow, bus_quiet;
    logic [1:0]  bresp, rresp;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  wstrb = 4'hF;
    eff_type     trx_mode;
    power_type   power_mode;
    int          errors = 0, tests_run = 0;
    can_swk_mode_ctrl can_swk_mode_ctrl_i (.*);
    can_bus_model     can_bus_model_i (.*);
    // Clock and a toggling transmit line
    always #20 aclk = ~aclk;
    always @(posedge aclk) txd_pin <= ~txd_pin;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One AXI4-Lite transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        logic got;
        got = 1'b0;
        r = 32'h0;
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            got = w ? bvalid : rvalid;
            r = w ? {30'h0, bresp} : rdata;
        end
        {bready, rready} <= 2'b00;
        if (!got) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0, q);
        check(q, want);
    endtask
    task automatic md(input logic [2:0] d);
        wr(ADDR_CAN_MODE, 32'(d));
    endtask
    task automatic pw(input logic [1:0] d);
        wr(ADDR_POWER_CMD, 32'(d));
    endtask
    // Every code read back and mapped in Normal
    task automatic t_modes();
        for (int c = 0; c < 8; c++) begin
            md(3'(c));
            rd(ADDR_CAN_MODE, 32'(c));
            check(32'(trx_mode), c == 4 ? 32'h0 : 32'(c % 4));
        end
        rd(ADDR_SWK_CFG, 32'h2);
        bus(1'b1, 8'h20, 32'h0, q);
        check(q, 32'(RESP_SLVERR));
    endtask
    // Stop entry with and without a valid setup
    task automatic t_stop();
        md(3'h3);
        pw(2'h1);
        check(32'(trx_mode), 32'(EFF_WAKE));
        pw(2'h0);
        wr(ADDR_SWK_CFG, 32'h1);
        md(3'h7);
        rd(ADDR_STATUS, 32'h0F);
        pw(2'h1);
        md(3'h1);
        rd(ADDR_STATUS, 32'h10F);
        rd(ADDR_CAN_MODE, 32'h7);
        pw(2'h0);
        md(3'h3);
        wr(ADDR_SWK_CFG, 32'h0);
        md(3'h5);
        pw(2'h1);
        check(32'(trx_mode), 32'(EFF_WAKE));
        rd(ADDR_CAN_MODE, 32'h5);
        pw(2'h0);
    endtask
    // Sleep, frame wake, restart, rearm
    task automatic t_sleep();
        md(3'h3);
        wr(ADDR_SWK_CFG, 32'h1);
        md(3'h6);
        pw(2'h2);
        rd(ADDR_CAN_MODE, 32'h5);
        check(32'(trx_mode), 32'(EFF_SWK));
        can_bus_model_i.event_pulse(4'h8);
        rd(ADDR_SWK_CFG, 32'h0);
        rd(ADDR_CAN_MODE, 32'h5);
        check(32'(power_mode), 32'(POWER_RESTART));
        check(32'(rxd_pin), 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        check(q & 32'h8, 32'h0);
        pw(2'h0);
        pw(2'h2);
        check(32'(trx_mode == EFF_WOKEN), 32'h0);
        for (int c = 2; c < 5; c += 2) begin
            pw(2'h0);
            md(3'(c));
            pw(2'h2);
            rd(ADDR_CAN_MODE, c == 2 ? 32'h1 : 32'h4);
        end
        pw(2'h0);
    endtask
    // Wake and silence interrupts
    task automatic t_irq();
        md(3'h3);
        wr(ADDR_SWK_CFG, 32'h1);
        md(3'h7);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        can_bus_model_i.event_pulse(4'h8);
        rd(ADDR_IRQ_STATUS, 32'h1);
        check(32'(irq), 32'h1);
        wr(ADDR_IRQ_CLEAR, 32'h1);
        md(3'h3);
        md(3'h7);
        can_bus_model_i.event_pulse(4'h1);
        rd(ADDR_IRQ_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h1F);
        can_bus_model_i.event_pulse(4'h4);
        rd(ADDR_STATUS, 32'h0F);
        check(32'(irq), 32'h0);
        wr(ADDR_IRQ_ENABLE, 32'h2);
        check(32'(irq), 32'h1);
        wr(ADDR_IRQ_CLEAR, 32'h2);
        check(32'(irq), 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_modes();
        t_stop();
        t_sleep();
        t_irq();
        wrap_up();
    end
endmodule
